// ### logic/svp_pkg.sv
// constants and carrier types for the servo loop position controller
package svp_pkg;
  localparam int POS_W = 32; // position counter width, quad counts
  localparam int DEM_W = 16; // signed demand word width
  localparam int FIX_W = 16; // 8.8 unsigned gain and limit fields
  localparam int FRAC_W = 8; // fractional bits, steps of 1/256
  localparam int ACC_W = 48; // internal arithmetic width
  localparam int TQ_W = 8; // signed direct torque percentage
  localparam int CLK_PERIOD_NS = 10; // core_clk at 100 MHz
  localparam int NS_PER_MS = 1000000;
  localparam int LOOP_SLOW_MS = 2; // default loop period
  localparam int LOOP_FAST_MS = 1; // optional faster loop period
  localparam int LOOP_SLOW_CYC = LOOP_SLOW_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int LOOP_FAST_CYC = LOOP_FAST_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 18; // holds LOOP_SLOW_CYC
  localparam int PCT_FULL = 100; // percent of full scale
  localparam logic [FIX_W-1:0] GAIN_RST = 16'h0000;
  localparam logic signed [ACC_W-1:0] DEM_FS = 48'sh0000_0000_7fff; // full-scale, +/-10 V
  localparam logic [31:0] PCT_DIV = 32'h0000_6400; // 100 * 256, percent in 8.8

  // per-axis gain and limit set, each an 8.8 unsigned value
  typedef struct packed {
    logic [FIX_W-1:0] prop;
    logic [FIX_W-1:0] vfb;
    logic [FIX_W-1:0] vff;
    logic [FIX_W-1:0] integ;
    logic [FIX_W-1:0] iclamp;
    logic [FIX_W-1:0] oclamp;
  } svp_gains_s;

  // per-axis observed state
  typedef struct packed {
    logic [POS_W-1:0] position;
    logic [POS_W-1:0] ferr;
    logic [POS_W-1:0] vel;
    logic [DEM_W-1:0] demand;
  } svp_axis_stat_s;
endpackage : svp_pkg

// ### logic/svp_quad.sv
// quadrature decoder and position counter for one encoder input
module svp_quad (
  input wire logic core_clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic enc_a, // encoder channel a pin
  input wire logic enc_b, // encoder channel b pin
  output logic [svp_pkg::POS_W-1:0] position // signed count, registered
);
  logic [1:0] sync1_r;
  logic [1:0] sync1_nxt;
  logic [1:0] sync2_r;
  logic [1:0] sync2_nxt;
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;
  logic [svp_pkg::POS_W-1:0] cnt_r;
  logic [svp_pkg::POS_W-1:0] cnt_nxt;

  // +1, -1 or 0 for a gray step; a two-bit jump is a missed edge and ignored
  function automatic logic [svp_pkg::POS_W-1:0] step(input logic [1:0] p, input logic [1:0] c);
    unique case ({p, c})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step = 32'h0000_0001;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step = 32'hffff_ffff;
      default: step = 32'h0000_0000;
    endcase
  endfunction : step

  ////////////////////////////////////////////////////////////////////////
  // next state: two-flop sync, then every edge of both channels counts
  always_comb begin
    sync1_nxt = {enc_a, enc_b};
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    cnt_nxt = cnt_r + step(prev_r, sync2_r);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r <= 2'h0;
      cnt_r <= 32'h0000_0000;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign position = cnt_r;
endmodule : svp_quad

// ### logic/svp_ctrl.sv
// multi-axis closed-loop position controller with quadrature feedback
module svp_ctrl #(
  parameter int NUM_AXES = 2,
  parameter int LOOP_SLOW_CYC = svp_pkg::LOOP_SLOW_CYC,
  parameter int LOOP_FAST_CYC = svp_pkg::LOOP_FAST_CYC
) (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic [NUM_AXES-1:0] enc_a, // encoder channel a pins
  input wire logic [NUM_AXES-1:0] enc_b, // encoder channel b pins
  input wire logic gains_load, // one-cycle strobe, copies gains_in
  input wire svp_pkg::svp_gains_s [NUM_AXES-1:0] gains_in, // gains per axis
  input wire logic [NUM_AXES-1:0][svp_pkg::POS_W-1:0] demand_pos, // demanded position
  input wire logic [NUM_AXES-1:0] torque_mode, // open-loop torque per axis
  input wire logic [NUM_AXES-1:0][svp_pkg::TQ_W-1:0] direct_torque_setting, // signed percent
  input wire logic loop_period_select, // 1 selects 1 ms loop
  input wire logic stop_in, // stop pin, active high
  output svp_pkg::svp_axis_stat_s [NUM_AXES-1:0] axis_stat, // per-axis state
  output logic loop_tick // one-cycle pulse at each update
);
  localparam int AW = svp_pkg::ACC_W;
  localparam int PW = svp_pkg::POS_W;
  localparam int DW = svp_pkg::DEM_W;
  localparam int CW = svp_pkg::TICK_CNT_W;
  localparam logic [CW-1:0] SLOW_LAST = CW'(LOOP_SLOW_CYC - 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(LOOP_FAST_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // 8.8 gain times signed value, fraction dropped
  function automatic logic signed [AW-1:0] fmul(input logic [svp_pkg::FIX_W-1:0] g,
                                                input logic signed [AW-1:0] x);
    logic signed [AW+svp_pkg::FIX_W:0] p;
    p = $signed({1'b0, g}) * x;
    fmul = AW'(p >>> svp_pkg::FRAC_W);
  endfunction : fmul

  // 8.8 percentage to a demand magnitude, capped at full scale
  function automatic logic signed [AW-1:0] pct_lim(input logic [svp_pkg::FIX_W-1:0] pct);
    logic [31:0] t;
    t = (32'(pct) * 32'(svp_pkg::DEM_FS)) / svp_pkg::PCT_DIV;
    if ($signed(AW'(t)) > svp_pkg::DEM_FS) begin
      pct_lim = svp_pkg::DEM_FS;
    end else begin
      pct_lim = $signed(AW'(t));
    end
  endfunction : pct_lim

  // symmetric clamp to +/- lim
  function automatic logic signed [AW-1:0] sat(input logic signed [AW-1:0] x,
                                               input logic signed [AW-1:0] lim);
    if (x > lim) begin
      sat = lim;
    end else if (x < -lim) begin
      sat = -lim;
    end else begin
      sat = x;
    end
  endfunction : sat

  ////////////////////////////////////////////////////////////////////////
  // encoder inputs, one decoder per axis

  logic [NUM_AXES-1:0][PW-1:0] pos;

  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    svp_quad u_quad (
      .core_clk(core_clk),
      .nrst(nrst),
      .enc_a(enc_a[i]),
      .enc_b(enc_b[i]),
      .position(pos[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // stop pin synchroniser and loop timebase

  logic stop1_r;
  logic stop1_nxt;
  logic stop2_r;
  logic stop2_nxt;
  logic [CW-1:0] tick_cnt_r;
  logic [CW-1:0] tick_cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [CW-1:0] last;

  // period change applies to the count in progress, which wraps at once if already past
  always_comb begin
    stop1_nxt = stop_in;
    stop2_nxt = stop1_r;
    last = loop_period_select ? FAST_LAST : SLOW_LAST;
    tick_nxt = (tick_cnt_r >= last);
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stop1_r <= 1'b0;
      stop2_r <= 1'b0;
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      stop1_r <= stop1_nxt;
      stop2_r <= stop2_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-axis loop state

  svp_pkg::svp_gains_s [NUM_AXES-1:0] gains_r;
  svp_pkg::svp_gains_s [NUM_AXES-1:0] gains_nxt;
  logic [NUM_AXES-1:0][PW-1:0] pos_prev_r;
  logic [NUM_AXES-1:0][PW-1:0] pos_prev_nxt;
  logic [NUM_AXES-1:0][PW-1:0] dpos_prev_r;
  logic [NUM_AXES-1:0][PW-1:0] dpos_prev_nxt;
  logic [NUM_AXES-1:0][AW-1:0] iterm_r;
  logic [NUM_AXES-1:0][AW-1:0] iterm_nxt;
  logic [NUM_AXES-1:0][PW-1:0] ferr_r;
  logic [NUM_AXES-1:0][PW-1:0] ferr_nxt;
  logic [NUM_AXES-1:0][PW-1:0] vel_r;
  logic [NUM_AXES-1:0][PW-1:0] vel_nxt;
  logic [NUM_AXES-1:0][DW-1:0] dem_r;
  logic [NUM_AXES-1:0][DW-1:0] dem_nxt;

  // control law, evaluated every cycle but only committed on the tick
  always_comb begin
    logic signed [AW-1:0] e;
    logic signed [AW-1:0] v;
    logic signed [AW-1:0] dv;
    logic signed [AW-1:0] ilim;
    logic signed [AW-1:0] olim;
    logic signed [AW-1:0] isum;
    logic signed [AW-1:0] total;
    logic signed [AW-1:0] tq;
    e = '0;
    v = '0;
    dv = '0;
    ilim = '0;
    olim = '0;
    isum = '0;
    total = '0;
    tq = '0;
    gains_nxt = gains_r;
    pos_prev_nxt = pos_prev_r;
    dpos_prev_nxt = dpos_prev_r;
    iterm_nxt = iterm_r;
    ferr_nxt = ferr_r;
    vel_nxt = vel_r;
    dem_nxt = dem_r;
    if (gains_load) begin
      gains_nxt = gains_in;
    end
    for (int i = 0; i < NUM_AXES; i++) begin
      // wrap-safe differences in counts and counts per loop period
      e = AW'($signed(PW'(demand_pos[i] - pos[i])));
      v = AW'($signed(PW'(pos[i] - pos_prev_r[i])));
      dv = AW'($signed(PW'(demand_pos[i] - dpos_prev_r[i])));
      ilim = pct_lim(gains_r[i].iclamp);
      olim = pct_lim(gains_r[i].oclamp);
      // integral kept as its contribution so the clamp is exact, no wrap
      isum = sat(sat(AW'($signed(iterm_r[i])), ilim) + fmul(gains_r[i].integ, e), ilim);
      total = fmul(gains_r[i].prop, e) - fmul(gains_r[i].vfb, v)
              + fmul(gains_r[i].vff, dv) + isum;
      total = sat(total, olim);
      tq = AW'($signed(direct_torque_setting[i])) * svp_pkg::DEM_FS / AW'(svp_pkg::PCT_FULL);
      if (stop2_r) begin
        // integral held at zero while stopped, so release does not kick
        iterm_nxt[i] = '0;
        dem_nxt[i] = '0;
      end else if (tick_r) begin
        ferr_nxt[i] = PW'(e);
        vel_nxt[i] = PW'(v);
        pos_prev_nxt[i] = pos[i];
        dpos_prev_nxt[i] = demand_pos[i];
        iterm_nxt[i] = torque_mode[i] ? '0 : isum;
        dem_nxt[i] = torque_mode[i] ? DW'(sat(tq, svp_pkg::DEM_FS)) : DW'(total);
      end
    end
  end

  // loop registers; gains clear to zero so power-up gives no demand outside torque mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_AXES; i++) begin
        gains_r[i] <= '{svp_pkg::GAIN_RST, svp_pkg::GAIN_RST, svp_pkg::GAIN_RST,
                        svp_pkg::GAIN_RST, svp_pkg::GAIN_RST, svp_pkg::GAIN_RST};
      end
      pos_prev_r <= '0;
      dpos_prev_r <= '0;
      iterm_r <= '0;
      ferr_r <= '0;
      vel_r <= '0;
      dem_r <= '0;
    end else begin
      gains_r <= gains_nxt;
      pos_prev_r <= pos_prev_nxt;
      dpos_prev_r <= dpos_prev_nxt;
      iterm_r <= iterm_nxt;
      ferr_r <= ferr_nxt;
      vel_r <= vel_nxt;
      dem_r <= dem_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      axis_stat[i].position = pos[i];
      axis_stat[i].ferr = ferr_r[i];
      axis_stat[i].vel = vel_r[i];
      axis_stat[i].demand = dem_r[i];
    end
  end

  assign loop_tick = tick_r;
endmodule : svp_ctrl

// ### verif/svp_ctrl_properties.sv
// port checker for the servo loop position controller
module svp_ctrl_chk #(
  parameter int NUM_AXES = 2,
  parameter int LOOP_SLOW_CYC = svp_pkg::LOOP_SLOW_CYC,
  parameter int LOOP_FAST_CYC = svp_pkg::LOOP_FAST_CYC
) (
  input wire logic core_clk, // clock
  input wire logic nrst, // reset
  input wire logic [NUM_AXES-1:0] enc_a, // chan a
  input wire logic [NUM_AXES-1:0] enc_b, // chan b
  input wire logic gains_load, // strobe
  input wire svp_pkg::svp_gains_s [NUM_AXES-1:0] gains_in, // gains
  input wire logic [NUM_AXES-1:0][svp_pkg::POS_W-1:0] demand_pos, // target
  input wire logic [NUM_AXES-1:0] torque_mode, // open loop
  input wire logic [NUM_AXES-1:0][svp_pkg::TQ_W-1:0] direct_torque_setting, // torque
  input wire logic loop_period_select, // period
  input wire logic stop_in, // stop
  input wire svp_pkg::svp_axis_stat_s [NUM_AXES-1:0] axis_stat, // state
  input wire logic loop_tick // tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [17:0] cnt_r;
  logic [3:0] pv_r;
  logic [2:0] qc_r;
  logic [4:0] sh_r;
  logic [31:0] cap_r;
  logic ok_r, sel_r, ld_r, fwd, rev, quiet;
  // torque percent to full scale, clipped
  function automatic int tqd(input logic [7:0] t);
    int r;
    r = $signed(t) * 32767 / 100;
    return r > 32767 ? 32767 : (r < -32767 ? -32767 : r);
  endfunction : tqd
  // counting up: new a is old b, new b is old a inverted
  assign fwd = {enc_a[0], enc_b[0]} == {pv_r[1], ~pv_r[0]};
  assign rev = pv_r[1:0] == {~enc_a[0], enc_b[0]};
  assign quiet = !stop_in && sh_r == 5'h00;
  // history; stop window covers the pin synchroniser
  always_ff @(posedge core_clk) begin
    pv_r <= {enc_b[1], enc_a[1], enc_b[0], enc_a[0]};
    sel_r <= loop_period_select;
    sh_r <= {sh_r[3:0], stop_in};
    cnt_r <= loop_tick ? 18'h00001 : cnt_r + 18'h00001;
    cap_r <= fwd ? axis_stat[0].position + 1 : (rev ? axis_stat[0].position - 1 : cap_r);
    qc_r <= (pv_r[3:2] != {enc_b[1], enc_a[1]}) ? 3'h0 : (qc_r == 3'h7 ? qc_r : qc_r + 3'h1);
    ok_r <= nrst && (loop_tick || ok_r) && (sel_r == loop_period_select);
    ld_r <= nrst && (ld_r || gains_load || |torque_mode);
  end
  ////////////////////////////////////////////////////////////////
  a_tick_pulse: assert property (loop_tick |=> !loop_tick) else $error("tick too wide");
  a_tick_period: assert property (loop_tick && ok_r && sel_r == loop_period_select
    |-> cnt_r == (loop_period_select ? LOOP_FAST_CYC : LOOP_SLOW_CYC)) else $error("loop period wrong");
  a_demand_hold: assert property (!$past(loop_tick) && quiet |-> $stable(axis_stat[0].demand))
    else $error("demand moved off tick");
  a_stop_zero: assert property (stop_in [*4] |=> axis_stat[0].demand == 16'h0000
    && axis_stat[1].demand == 16'h0000) else $error("demand during stop");
  a_enc_count: assert property (fwd || rev |=> ##[0:4] axis_stat[0].position == cap_r)
    else $error("quadrature count wrong");
  a_axis_isolate: assert property (qc_r >= 3'h5 |-> $stable(axis_stat[1].position))
    else $error("axis 1 moved without its pins");
  a_gains_zero: assert property (!ld_r |-> axis_stat[0].demand == 16'h0000
    && axis_stat[1].demand == 16'h0000) else $error("demand with zero gains");
  a_torque_scale: assert property (loop_tick && torque_mode[0] && quiet
    |=> $signed(axis_stat[0].demand) == tqd($past(direct_torque_setting[0]))) else $error("torque scale");
  c_fast: cover property (loop_tick && loop_period_select);
  c_stop: cover property (stop_in [*4]);
  c_torque: cover property (loop_tick && torque_mode[0]);
endmodule : svp_ctrl_chk
bind svp_ctrl svp_ctrl_chk #(.NUM_AXES(NUM_AXES), .LOOP_SLOW_CYC(LOOP_SLOW_CYC), .LOOP_FAST_CYC(LOOP_FAST_CYC)) u_chk (.*);

// ### verif/svp_enc_model.sv
// motor shaft and quadrature encoder model
module svp_enc_model (
  input wire logic core_clk, // clock
  input wire logic step, // one count
  input wire logic dir, // 1 forward
  output logic enc_a, // chan a
  output logic enc_b // chan b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r = 2'h0;
  // gray output: only one pin moves per count; forward walks {a,b} 00,01,11,10
  always @(posedge core_clk) begin
    if (step) begin
      ph_r <= dir ? ph_r + 2'h1 : ph_r - 2'h1;
    end
  end
  assign enc_a = ph_r[1];
  assign enc_b = ph_r[0] ^ ph_r[1];
endmodule : svp_enc_model

// ### verif/svp_ctrl_tb.sv
// self-checking bench for the servo loop position controller
module svp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, gains_load, loop_period_select, stop_in, loop_tick;
  logic [1:0] enc_a, enc_b, torque_mode, step, dir;
  svp_pkg::svp_gains_s [1:0] gains_in;
  logic [1:0][31:0] demand_pos;
  logic [1:0][7:0] direct_torque_setting;
  svp_pkg::svp_axis_stat_s [1:0] axis_stat;
  logic [143:0] exp_q[$];
  logic [7:0] tqv [7] = '{8'h64, 8'h9c, 8'h01, 8'hff, 8'h32, 8'h7f, 8'h80};
  int failures = 0;
  int samples_checked = 0;
  int e;
  svp_ctrl #(.NUM_AXES(2), .LOOP_SLOW_CYC(40), .LOOP_FAST_CYC(20)) uut (.*);
  svp_enc_model m0 (.core_clk(core_clk), .step(step[0]), .dir(dir[0]), .enc_a(enc_a[0]), .enc_b(enc_b[0]));
  svp_enc_model m1 (.core_clk(core_clk), .step(step[1]), .dir(dir[1]), .enc_a(enc_a[1]), .enc_b(enc_b[1]));
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    // a note never checked counts against the run
    failures += exp_q.size();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // tick result against oldest note
  task automatic check_tick(input logic [143:0] ex, input logic [143:0] got);
    samples_checked++;
    if (got !== ex) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask : check_tick
  // turn a shaft n counts; 8 cycles apart keeps pins settled
  task automatic move(input int ax, input int n, input logic d);
    repeat (n) begin
      @(posedge core_clk);
      step[ax] <= 1'b1;
      dir[ax] <= d;
      @(posedge core_clk);
      step[ax] <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask : move
  // gain set, vfb left at zero
  function automatic svp_pkg::svp_gains_s mk(input logic [15:0] p, input logic [15:0] ff,
                                             input logic [15:0] ki, input logic [15:0] ic, input logic [15:0] oc);
    return '{prop: p, vfb: 16'h0000, vff: ff, integ: ki, iclamp: ic, oclamp: oc};
  endfunction : mk
  // torque percent to demand, truncated then clipped
  function automatic logic [15:0] tqx(input logic [7:0] t);
    int r;
    r = $signed(t) * 32767 / 100;
    r = r > 32767 ? 32767 : (r < -32767 ? -32767 : r);
    return r[15:0];
  endfunction : tqx
  // drive at a tick edge, note the next tick's result; axis 0 rests at 7, so no velocity
  task automatic apply(input svp_pkg::svp_gains_s g, input logic [31:0] dp, input logic [7:0] tq,
                       input logic tm, input logic s, input logic [15:0] dem);
    @(posedge core_clk iff loop_tick);
    gains_in <= {g, g};
    gains_load <= 1'b1;
    demand_pos[0] <= dp;
    direct_torque_setting[0] <= tq;
    torque_mode[0] <= tm;
    stop_in <= s;
    @(posedge core_clk);
    gains_load <= 1'b0;
    #2;
    exp_q.push_back({32'hffff_fffb, 32'h0000_0007, dp - 32'h0000_0007, 32'h0000_0000, dem});
  endtask : apply
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watcher: demand lands one edge after the tick
  initial begin
    forever begin
      @(posedge core_clk iff loop_tick);
      @(posedge core_clk);
      #1;
      if (exp_q.size() > 0) begin
        check_tick(exp_q.pop_front(), {axis_stat[1].position, axis_stat[0].position, axis_stat[0].ferr,
                                       axis_stat[0].vel, axis_stat[0].demand});
      end
    end
  end
  // watchdog, far beyond the expected run
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h14112569));
    {nrst, gains_load, loop_period_select, stop_in, torque_mode, step, dir} = '0;
    gains_in = '0;
    demand_pos = '0;
    direct_torque_setting = '0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    exp_q.push_back(144'h0);
    @(posedge core_clk iff loop_tick);
    move(0, 10, 1'b1);
    move(0, 3, 1'b0);
    move(1, 5, 1'b0);
    repeat (4) begin
      e = int'($urandom_range(2000)) - 1000;
      apply(mk(16'h0100, 16'h0, 16'h0, 16'h6400, 16'h6400), 32'(7 + e), 8'h0, 1'b0, 1'b0, e[15:0]);
    end
    apply(mk(16'h0100, 16'h0, 16'h0, 16'h6400, 16'h3200), 32'd30007, 8'h0, 1'b0, 1'b0, 16'h3fff);
    @(posedge core_clk);
    loop_period_select <= 1'b1;
    apply(mk(16'h0100, 16'h0, 16'h0, 16'h6400, 16'h3200), -32'sd29993, 8'h0, 1'b0, 1'b0, 16'hc001);
    for (int i = 0; i < 7; i++) begin
      apply(mk(16'h0, 16'h0, 16'h0, 16'h6400, 16'h6400), 32'd7, tqv[i], 1'b1, 1'b0, tqx(tqv[i]));
    end
    apply(mk(16'h0, 16'h0, 16'h0, 16'h6400, 16'h6400), 32'd7, 8'h64, 1'b1, 1'b1, 16'h0000);
    for (int i = 1; i <= 5; i++) begin
      apply(mk(16'h0, 16'h0, 16'h0100, 16'h0100, 16'h6400), 32'd107, 8'h0, 1'b0, 1'b0,
            16'(i < 4 ? 100 * i : 327));
    end
    // integral of 327 left by the windup steps still adds in
    apply(mk(16'h0, 16'h0100, 16'h0, 16'h6400, 16'h6400), 32'd607, 8'h0, 1'b0, 1'b0, 16'd827);
    apply(mk(16'h0, 16'h0100, 16'h0, 16'h6400, 16'h6400), 32'd607, 8'h0, 1'b0, 1'b0, 16'd327);
    @(posedge core_clk iff loop_tick);
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule : svp_ctrl_tb
